// ---- hdl/rtc_map.svh ----
// register offsets, field positions, reset values and timing counts of the rtc core
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

`define RTC_SEC_ADDR 4'h0
`define RTC_MIN_ADDR 4'h1
`define RTC_HOUR_ADDR 4'h2
`define RTC_DAY_ADDR 4'h3
`define RTC_DATE_ADDR 4'h4
`define RTC_MONTH_ADDR 4'h5
`define RTC_YEAR_ADDR 4'h6
`define RTC_A1_FIRST_ADDR 4'h7
`define RTC_A1_LAST_ADDR 4'ha
`define RTC_A2_FIRST_ADDR 4'hb
`define RTC_A2_LAST_ADDR 4'hd
`define RTC_CTRL_ADDR 4'he
`define RTC_STAT_ADDR 4'hf

`define RTC_SEC_MASK 8'h7f
`define RTC_MIN_MASK 8'h7f
`define RTC_HOUR_MASK 8'h7f
`define RTC_DAY_MASK 8'h07
`define RTC_DATE_MASK 8'h3f
`define RTC_MONTH_MASK 8'h9f
`define RTC_YEAR_MASK 8'hff
`define RTC_CTRL_MASK 8'h9f
`define RTC_STAT_MASK 8'h83

`define RTC_CTRL_RST 8'h18
`define RTC_STAT_RST 8'h80
`define RTC_SEC_RST 8'h00
`define RTC_MIN_RST 8'h00
`define RTC_HOUR_RST 8'h00
`define RTC_DAY_RST 8'h01
`define RTC_DATE_RST 8'h01
`define RTC_MONTH_RST 8'h01
`define RTC_YEAR_RST 8'h00
`define RTC_ALARM_RST 8'h00

`define CTRL_OSC_DIS_BIT 7
`define CTRL_RATE_HI_BIT 4
`define CTRL_RATE_LO_BIT 3
`define CTRL_ROUTE_BIT 2
`define CTRL_A2_IE_BIT 1
`define CTRL_A1_IE_BIT 0
`define STAT_OSF_BIT 7
`define STAT_A2F_BIT 1
`define STAT_A1F_BIT 0
`define HOUR_12_BIT 6
`define HOUR_PM_BIT 5
`define MONTH_CENT_BIT 7
`define ALARM_MASK_BIT 7
`define ALARM_DYDT_BIT 6

`define OSC_DIV_DFLT 32768
`define OSC_CNT_W 16

`endif

// ---- hdl/rtc_pkg.sv ----
// types of the rtc core: register request and per-domain state
`include "rtc_map.svh"
package rtc_pkg;

   typedef struct packed {
      logic wr;
      logic [3:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic tick_s1;
      logic tick_s2;
      logic tick_s3;
      logic wave_s1;
      logic wave_s2;
      logic chk;
      logic [6:0][7:0] tm;
      logic [3:0][7:0] a1;
      logic [2:0][7:0] a2;
      logic [7:0] ctrl;
      logic [7:0] stat;
      logic [7:0] rdata;
      logic a_oe;
      logic b_oe;
   } sys_state_t;

   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic dis_s1;
      logic dis_s2;
      logic [1:0] rate_s1;
      logic [1:0] rate_s2;
      logic [`OSC_CNT_W-1:0] cnt;
      logic tick_tgl;
      logic tg_p;
      logic wave;
   } osc_state_t;

endpackage

// ---- hdl/rtc_core.sv ----
// rtc timekeeping core: bcd calendar, two alarms, control/status, square wave
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.svh"

// Summary of operation
// RULE_01: time and calendar kept in bcd
// RULE_02: hours bit 6 selects 12-hour mode
// RULE_03: 12-hour mode bit 5 marks afternoon
// RULE_04: 24-hour mode bit 5 is twenty digit
// RULE_05: century bit flips on year 99 to 00
// RULE_06: first alarm at offsets 07h to 0ah
// RULE_07: second alarm at 0bh to 0dh, no seconds
// RULE_08: bit 7 masks; all zero means full match
// RULE_09: first alarm mask patterns select repeat rate
// RULE_10: second alarm mask patterns select repeat rate
// RULE_11: host programs only listed mask combinations
// RULE_12: bit 6 picks weekday or monthday compare
// RULE_13: match sets flag; enable gates interrupt
// RULE_14: control bit 7 stops oscillator, resets zero
// RULE_15: rate select picks square wave frequency
// RULE_16: rate select resets to 32khz setting
// RULE_17: routing one: alarm one to a, two to b
// RULE_18: routing zero: both alarms to a
// RULE_19: routing zero puts square wave on b
// RULE_20: routing bit resets to zero
// RULE_21: alarm one enable gates output a
// RULE_22: alarm two enable gates routed output
// RULE_23: flag cleared by zero write only
// RULE_24: active interrupt pulls pin low, open drain
// RULE_25: stop flag sets on oscillator stop, sticky
// RULE_26: seconds tick per divider period, full carry
// RULE_27: weekday counts 1 to 7 then wraps
module rtc_core
   import rtc_pkg::*;
#(
   parameter int OSC_DIV = `OSC_DIV_DFLT
) (
   input wire logic SYS_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic OSC_CLK_I,
   input wire reg_req_t REG_REQ_I,
   output logic [7:0] REG_RD_DATA_O,
   output logic IRQ_OUT_A_O,
   output logic IRQ_OUT_A_OE_O,
   output logic WAVE_OR_IRQ_OUT_B_O,
   output logic WAVE_OR_IRQ_OUT_B_OE_O
);

   localparam logic [`OSC_CNT_W-1:0] DIV_LAST = `OSC_CNT_W'(OSC_DIV - 1);
   localparam logic [`OSC_CNT_W-1:0] DIV_HALF = `OSC_CNT_W'(OSC_DIV / 2);

   sys_state_t s_r;
   sys_state_t s_nxt;
   osc_state_t o_r;
   osc_state_t o_nxt;
   logic tg_n_r;
   logic wave_src;

   // {wrap, next} of a bcd counter running first..last
   function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                           input logic [7:0] first);
      if (v == last) begin
         return {1'b1, first};
      end
      if (v[3:0] == 4'h9) begin
         return {1'b0, v[7:4] + 4'h1, 4'h0};
      end
      return {1'b0, v[7:4], v[3:0] + 4'h1};
   endfunction

   // two-digit year only: 00 counts as leap, so a non-leap century year is wrong
   function automatic logic is_leap(input logic [7:0] y);
      if (y[4]) begin
         return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end
      return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
   endfunction

   function automatic logic [7:0] last_date(input logic [7:0] mon, input logic [7:0] y);
      unique case (mon[4:0])
         5'h02: return is_leap(y) ? 8'h29 : 8'h28;
         5'h04, 5'h06, 5'h09, 5'h11: return 8'h30;
         default: return 8'h31;
      endcase
   endfunction

   // writable bits per offset; the rest read as zero
   function automatic logic [7:0] reg_mask(input logic [3:0] a);
      unique case (a)
         `RTC_SEC_ADDR: return `RTC_SEC_MASK;
         `RTC_MIN_ADDR: return `RTC_MIN_MASK;
         `RTC_HOUR_ADDR: return `RTC_HOUR_MASK;
         `RTC_DAY_ADDR: return `RTC_DAY_MASK;
         `RTC_DATE_ADDR: return `RTC_DATE_MASK;
         `RTC_MONTH_ADDR: return `RTC_MONTH_MASK;
         `RTC_YEAR_ADDR: return `RTC_YEAR_MASK;
         `RTC_CTRL_ADDR: return `RTC_CTRL_MASK;
         `RTC_STAT_ADDR: return `RTC_STAT_MASK;
         default: return 8'hff;
      endcase
   endfunction

   function automatic logic dd_match(input logic [7:0] a, input logic [7:0] day,
                                     input logic [7:0] date);
      if (a[`ALARM_DYDT_BIT]) begin
         return a[5:0] == {3'h0, day[2:0]}; // RULE_12
      end
      return a[5:0] == date[5:0]; // RULE_12
   endfunction

   // one alarm field: masked, or equal in its seven value bits
   function automatic logic fld_hit(input logic [7:0] a, input logic [7:0] t);
      return a[`ALARM_MASK_BIT] || (a[6:0] == t[6:0]);
   endfunction

   // oscillator domain: divider, seconds toggle and square wave sources
   always_comb begin
      o_nxt = o_r;
      o_nxt.rst_s1 = SYS_RST_I;
      o_nxt.rst_s2 = o_r.rst_s1;
      o_nxt.dis_s1 = s_r.ctrl[`CTRL_OSC_DIS_BIT];
      o_nxt.dis_s2 = o_r.dis_s1;
      // the rate bits cross apart; a rate change may give one odd half period
      o_nxt.rate_s1 = {s_r.ctrl[`CTRL_RATE_HI_BIT], s_r.ctrl[`CTRL_RATE_LO_BIT]};
      o_nxt.rate_s2 = o_r.rate_s1;
      // a seconds write never restarts the divider, so the first second is short
      if (o_r.rst_s2) begin
         o_nxt.cnt = '0;
         o_nxt.tick_tgl = 1'b0;
         o_nxt.tg_p = 1'b0;
         o_nxt.wave = 1'b0;
      end else if (!o_r.dis_s2) begin // RULE_14
         if (o_r.cnt == DIV_LAST) begin
            o_nxt.cnt = '0;
            o_nxt.tick_tgl = ~o_r.tick_tgl; // RULE_26
         end else begin
            o_nxt.cnt = o_r.cnt + 1'b1;
         end
         o_nxt.tg_p = ~o_r.tg_p;
         unique case (o_r.rate_s2) // RULE_15
            2'b00: o_nxt.wave = (o_nxt.cnt >= DIV_HALF);
            2'b01: o_nxt.wave = o_nxt.cnt[2];
            2'b10: o_nxt.wave = o_nxt.cnt[1];
            2'b11: o_nxt.wave = 1'b0;
         endcase
      end
   end

   always_ff @(posedge OSC_CLK_I) begin
      o_r <= o_nxt;
   end

   // a falling-edge copy lets the full oscillator rate reach the pin
   always_ff @(negedge OSC_CLK_I) begin
      tg_n_r <= o_r.tg_p;
   end

   // edge xor is combinational; the two sync flops downstream absorb its glitches
   assign wave_src = (o_r.rate_s2 == 2'b11) ? (o_r.tg_p ^ tg_n_r) : o_r.wave; // RULE_15

   // system domain: registers, calendar, alarms and pins
   always_comb begin
      logic tick;
      logic [8:0] st;
      logic car;
      logic pm;
      logic [7:0] h;
      logic [7:0] wm;
      logic [3:0] off;
      logic hit1;
      logic hit2;
      logic f1_on;
      logic f2_on;
      tick = 1'b0;
      st = '0;
      car = 1'b0;
      pm = 1'b0;
      h = '0;
      wm = '0;
      off = '0;
      hit1 = 1'b0;
      hit2 = 1'b0;
      f1_on = 1'b0;
      f2_on = 1'b0;
      s_nxt = s_r;

      s_nxt.tick_s1 = o_r.tick_tgl;
      s_nxt.tick_s2 = s_r.tick_s1;
      s_nxt.tick_s3 = s_r.tick_s2;
      s_nxt.wave_s1 = wave_src;
      s_nxt.wave_s2 = s_r.wave_s1;
      // a tick that lands while stopped is dropped, not replayed
      tick = (s_r.tick_s2 ^ s_r.tick_s3) && !s_r.ctrl[`CTRL_OSC_DIS_BIT]; // RULE_14
      s_nxt.chk = tick;

      if (tick) begin
         st = bcd_step(s_r.tm[0], 8'h59, 8'h00); // RULE_26
         s_nxt.tm[0] = st[7:0];
         car = st[8];
         if (car) begin
            st = bcd_step(s_r.tm[1], 8'h59, 8'h00); // RULE_26
            s_nxt.tm[1] = st[7:0];
            car = st[8];
         end
         if (car) begin
            if (s_r.tm[2][`HOUR_12_BIT]) begin // RULE_02
               h = {3'h0, s_r.tm[2][4:0]};
               pm = s_r.tm[2][`HOUR_PM_BIT];
               car = 1'b0;
               if (h == 8'h11) begin
                  h = 8'h12;
                  car = pm; // RULE_03
                  pm = ~pm; // RULE_03
               end else begin
                  st = bcd_step(h, 8'h12, 8'h01);
                  h = st[7:0];
               end
               s_nxt.tm[2] = {1'b0, 1'b1, pm, h[4:0]}; // RULE_03
            end else begin
               st = bcd_step({2'h0, s_r.tm[2][5:0]}, 8'h23, 8'h00); // RULE_04
               s_nxt.tm[2] = {2'h0, st[5:0]}; // RULE_04
               car = st[8];
            end
         end
         if (car) begin
            st = bcd_step(s_r.tm[3], 8'h07, 8'h01); // RULE_27
            s_nxt.tm[3] = st[7:0];
            st = bcd_step(s_r.tm[4], last_date(s_r.tm[5], s_r.tm[6]), 8'h01); // RULE_26
            s_nxt.tm[4] = st[7:0];
            car = st[8];
         end
         if (car) begin
            st = bcd_step({3'h0, s_r.tm[5][4:0]}, 8'h12, 8'h01); // RULE_26
            s_nxt.tm[5] = {s_r.tm[5][`MONTH_CENT_BIT], 2'h0, st[4:0]};
            car = st[8];
         end
         if (car) begin
            st = bcd_step(s_r.tm[6], 8'h99, 8'h00); // RULE_26
            s_nxt.tm[6] = st[7:0];
            if (st[8]) begin
               s_nxt.tm[5][`MONTH_CENT_BIT] = ~s_r.tm[5][`MONTH_CENT_BIT]; // RULE_05
            end
         end
      end

      // compare one cycle after the tick, against the settled new time
      if (s_r.chk) begin
         hit1 = fld_hit(s_r.a1[0], s_r.tm[0]) && // RULE_09
                fld_hit(s_r.a1[1], s_r.tm[1]) && // RULE_08
                fld_hit(s_r.a1[2], s_r.tm[2]) && // RULE_08
                (s_r.a1[3][`ALARM_MASK_BIT] || dd_match(s_r.a1[3], s_r.tm[3], s_r.tm[4]));
         hit2 = (s_r.tm[0] == 8'h00) && // RULE_10
                fld_hit(s_r.a2[0], s_r.tm[1]) && // RULE_10
                fld_hit(s_r.a2[1], s_r.tm[2]) && // RULE_08
                (s_r.a2[2][`ALARM_MASK_BIT] || dd_match(s_r.a2[2], s_r.tm[3], s_r.tm[4]));
      end

      // a host write to a time register overrides the same-cycle carry
      if (REG_REQ_I.wr) begin
         wm = REG_REQ_I.wdata & reg_mask(REG_REQ_I.addr);
         if (REG_REQ_I.addr <= `RTC_YEAR_ADDR) begin
            s_nxt.tm[REG_REQ_I.addr[2:0]] = wm; // RULE_01
         end else if (REG_REQ_I.addr <= `RTC_A1_LAST_ADDR) begin
            off = REG_REQ_I.addr - `RTC_A1_FIRST_ADDR;
            s_nxt.a1[off[1:0]] = wm; // RULE_06
         end else if (REG_REQ_I.addr <= `RTC_A2_LAST_ADDR) begin
            off = REG_REQ_I.addr - `RTC_A2_FIRST_ADDR;
            s_nxt.a2[off[1:0]] = wm; // RULE_07
         end else if (REG_REQ_I.addr == `RTC_CTRL_ADDR) begin
            s_nxt.ctrl = wm; // RULE_15
         end else begin
            s_nxt.stat = s_r.stat & (wm | ~`RTC_STAT_MASK); // RULE_23
         end
      end

      // hardware set beats a same-cycle software clear
      if (hit1) begin
         s_nxt.stat[`STAT_A1F_BIT] = 1'b1; // RULE_13
      end
      if (hit2) begin
         s_nxt.stat[`STAT_A2F_BIT] = 1'b1; // RULE_13
      end
      if (s_r.ctrl[`CTRL_OSC_DIS_BIT]) begin
         s_nxt.stat[`STAT_OSF_BIT] = 1'b1; // RULE_25
      end

      f1_on = s_r.stat[`STAT_A1F_BIT] && s_r.ctrl[`CTRL_A1_IE_BIT]; // RULE_21
      f2_on = s_r.stat[`STAT_A2F_BIT] && s_r.ctrl[`CTRL_A2_IE_BIT]; // RULE_22
      // pins lag the flags by one cycle so every enable leaves a flop
      if (s_r.ctrl[`CTRL_ROUTE_BIT]) begin
         s_nxt.a_oe = f1_on; // RULE_17
         s_nxt.b_oe = f2_on; // RULE_17
      end else begin
         s_nxt.a_oe = f1_on || f2_on; // RULE_18
         s_nxt.b_oe = ~s_r.wave_s2; // RULE_19
      end

      if (REG_REQ_I.addr <= `RTC_YEAR_ADDR) begin
         s_nxt.rdata = s_r.tm[REG_REQ_I.addr[2:0]];
      end else if (REG_REQ_I.addr <= `RTC_A1_LAST_ADDR) begin
         off = REG_REQ_I.addr - `RTC_A1_FIRST_ADDR;
         s_nxt.rdata = s_r.a1[off[1:0]];
      end else if (REG_REQ_I.addr <= `RTC_A2_LAST_ADDR) begin
         off = REG_REQ_I.addr - `RTC_A2_FIRST_ADDR;
         s_nxt.rdata = s_r.a2[off[1:0]];
      end else if (REG_REQ_I.addr == `RTC_CTRL_ADDR) begin
         s_nxt.rdata = s_r.ctrl;
      end else begin
         s_nxt.rdata = s_r.stat;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         s_r <= '0;
         s_r.tm[0] <= `RTC_SEC_RST;
         s_r.tm[1] <= `RTC_MIN_RST;
         s_r.tm[2] <= `RTC_HOUR_RST;
         s_r.tm[3] <= `RTC_DAY_RST;
         s_r.tm[4] <= `RTC_DATE_RST;
         s_r.tm[5] <= `RTC_MONTH_RST;
         s_r.tm[6] <= `RTC_YEAR_RST;
         s_r.a1 <= {4{`RTC_ALARM_RST}};
         s_r.a2 <= {3{`RTC_ALARM_RST}};
         s_r.ctrl <= `RTC_CTRL_RST; // RULE_14 RULE_16 RULE_20
         s_r.stat <= `RTC_STAT_RST; // RULE_25
      end else begin
         s_r <= s_nxt;
      end
   end

   // open-drain pins: level always low, only the enable moves
   assign IRQ_OUT_A_O = 1'b0; // RULE_24
   assign WAVE_OR_IRQ_OUT_B_O = 1'b0; // RULE_24
   assign IRQ_OUT_A_OE_O = s_r.a_oe; // RULE_24
   assign WAVE_OR_IRQ_OUT_B_OE_O = s_r.b_oe;
   assign REG_RD_DATA_O = s_r.rdata;

endmodule // rtc_core

`default_nettype wire

// ---- bench/rtc_core_monitor.sv ----
// port assertions for the rtc core
`timescale 1ns/1ps
`default_nettype none
module rtc_core_monitor
   import rtc_pkg::*;
#(
   parameter int OSC_DIV = 32768
) (
   input wire logic SYS_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic OSC_CLK_I,
   input wire reg_req_t REG_REQ_I,
   input wire logic [7:0] REG_RD_DATA_O,
   input wire logic IRQ_OUT_A_O,
   input wire logic IRQ_OUT_A_OE_O,
   input wire logic WAVE_OR_IRQ_OUT_B_O,
   input wire logic WAVE_OR_IRQ_OUT_B_OE_O
);
   logic [7:0] ctrl_r;
   // mirror of the control register; the only state the checks need
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I)
         ctrl_r <= 8'h18;
      else if (REG_REQ_I.wr && REG_REQ_I.addr == 4'he)
         ctrl_r <= REG_REQ_I.wdata & 8'h9f;
   end
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   pin_a_low_a: assert property (IRQ_OUT_A_O == 1'b0)
      else $error("pin a data not low");
   pin_b_low_a: assert property (WAVE_OR_IRQ_OUT_B_O == 1'b0)
      else $error("pin b data not low");
   sec_bcd_a: assert property ($past(REG_REQ_I.addr) == 4'h0 |->
      REG_RD_DATA_O[7] == 1'b0 && REG_RD_DATA_O[3:0] <= 4'h9) else $error("seconds not bcd");
   stat_resv_a: assert property ($past(REG_REQ_I.addr) == 4'hf |->
      REG_RD_DATA_O[6:2] == 5'h00) else $error("status reserved bits set");
   ctrl_echo_a: assert property (REG_REQ_I.wr && REG_REQ_I.addr == 4'he ##1
      !REG_REQ_I.wr && REG_REQ_I.addr == 4'he |=> REG_RD_DATA_O == ($past(REG_REQ_I.wdata, 2)
      & 8'h9f)) else $error("control readback wrong");
   a_gate_a: assert property ((ctrl_r[1:0] == 2'b00) [*4] |-> !IRQ_OUT_A_OE_O)
      else $error("pin a active with enables off");
   route_a_a: assert property ((ctrl_r[2] && !ctrl_r[0]) [*4] |-> !IRQ_OUT_A_OE_O)
      else $error("alarm two reached pin a");
   route_b_a: assert property ((ctrl_r[2] && !ctrl_r[1]) [*4] |->
      !WAVE_OR_IRQ_OUT_B_OE_O) else $error("pin b active with enable off");
   wave_run_a: assert property ((!ctrl_r[7] && ctrl_r[4:2] == 3'b000) [*8] |->
      ##[0:48] $changed(WAVE_OR_IRQ_OUT_B_OE_O)) else $error("square wave stuck");
   osc_stop_a: assert property ((ctrl_r[7] && !ctrl_r[2]) [*8] |->
      $stable(WAVE_OR_IRQ_OUT_B_OE_O)) else $error("wave runs while stopped");
endmodule // rtc_core_monitor
bind rtc_core rtc_core_monitor #(.OSC_DIV(OSC_DIV)) u_rtc_core_monitor (.SYS_CLK_I, .SYS_RST_I,
   .OSC_CLK_I, .REG_REQ_I, .REG_RD_DATA_O, .IRQ_OUT_A_O, .IRQ_OUT_A_OE_O,
   .WAVE_OR_IRQ_OUT_B_O, .WAVE_OR_IRQ_OUT_B_OE_O);
`default_nettype wire

// ---- bench/rtc_host_model.sv ----
// host model: byte writes and reads on the register request port
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model
   import rtc_pkg::*;
(
   input wire logic clk_i,
   input wire logic [7:0] rd_data_i,
   output var reg_req_t req_o
);
   initial req_o = '0;
   // one-cycle write strobe; the next call waits a fresh edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{wr: 1'b1, addr: a, wdata: d};
      @(posedge clk_i);
      req_o.wr <= 1'b0;
   endtask
   // read data lags the address by one edge, taken once settled
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clk_i);
      @(posedge clk_i);
      #1 d = rd_data_i;
   endtask
endmodule // rtc_host_model
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the rtc core
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rtc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic osc = 1'b0;
   reg_req_t req;
   logic [7:0] rdata;
   logic a_o;
   logic a_oe;
   logic b_o;
   logic b_oe;
   int fails = 0;
   int samples_checked = 0;
   // short divider keeps a second at about 41 system cycles
   rtc_core #(.OSC_DIV(64)) u_rtc_core (.SYS_CLK_I(clk), .SYS_RST_I(rst), .OSC_CLK_I(osc),
      .REG_REQ_I(req), .REG_RD_DATA_O(rdata), .IRQ_OUT_A_O(a_o), .IRQ_OUT_A_OE_O(a_oe),
      .WAVE_OR_IRQ_OUT_B_O(b_o), .WAVE_OR_IRQ_OUT_B_OE_O(b_oe));
   rtc_host_model u_rtc_host_model (.clk_i(clk), .rd_data_i(rdata), .req_o(req));
   initial forever #50 clk = ~clk;
   initial begin
      #7;
      forever #32 osc = ~osc;
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_rtc_host_model.rd(a, d);
      chk($sformatf("reg %h", a), exp, d);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      u_rtc_host_model.wr(a, d);
   endtask
   task automatic wait_oe(input logic side_b);
      for (int n = 0; n < 200 && (side_b ? b_oe : a_oe) !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      chk("pin enable", 8'h01, {7'h00, side_b ? b_oe : a_oe});
   endtask
   // set the time with the oscillator stopped, then run to the next tick
   task automatic roll(input logic [7:0] s, input logic [7:0] m, input logic [7:0] h);
      logic [7:0] d;
      wr(4'h0, s);
      wr(4'h1, m);
      wr(4'h2, h);
      wr(4'he, 8'h00);
      d = s;
      for (int n = 0; n < 60 && d === s; n++) u_rtc_host_model.rd(4'h0, d);
      chk("seconds", 8'h00, d);
   endtask
   task automatic wave_chk(input logic [7:0] ctl, input logic run);
      int n;
      logic last;
      wr(4'he, ctl);
      repeat (20) @(posedge clk);
      n = 0;
      last = b_oe;
      repeat (100) begin
         @(posedge clk);
         #1;
         if (b_oe !== last) n++;
         last = b_oe;
      end
      chk("wave runs", {7'h00, run}, {7'h00, n > 0});
   endtask
   task automatic t_reset;
      rchk(4'he, 8'h18);
      rchk(4'hf, 8'h80);
      rchk(4'h3, 8'h01);
      wr(4'he, 8'hff);
      rchk(4'he, 8'h9f);
      $display("test reset done");
   endtask
   task automatic t_carry;
      wr(4'he, 8'h00);
      wr(4'hf, 8'h00);
      rchk(4'hf, 8'h00);
      wr(4'he, 8'h80);
      rchk(4'hf, 8'h80);
      wr(4'h3, 8'h07);
      wr(4'h4, 8'h28);
      wr(4'h5, 8'h02);
      wr(4'h6, 8'h99);
      roll(8'h59, 8'h59, 8'h23);
      rchk(4'h1, 8'h00);
      rchk(4'h2, 8'h00);
      rchk(4'h3, 8'h01);
      rchk(4'h4, 8'h01);
      rchk(4'h5, 8'h03);
      rchk(4'h6, 8'h99);
      wr(4'he, 8'h80);
      wr(4'h4, 8'h31);
      wr(4'h5, 8'h12);
      roll(8'h59, 8'h59, 8'h23);
      rchk(4'h5, 8'h81);
      rchk(4'h6, 8'h00);
      wr(4'he, 8'h80);
      roll(8'h59, 8'h59, 8'h51);
      rchk(4'h2, 8'h72);
      $display("test carry done");
   endtask
   task automatic t_alarm;
      wr(4'he, 8'h80);
      wr(4'h7, 8'h59);
      wr(4'h8, 8'h80);
      wr(4'h9, 8'h80);
      wr(4'ha, 8'h80);
      wr(4'hb, 8'h80);
      wr(4'hc, 8'h80);
      wr(4'hd, 8'h80);
      wr(4'h0, 8'h58);
      wr(4'he, 8'h07);
      wr(4'hf, 8'h00);
      wait_oe(1'b0);
      rchk(4'hf, 8'h01);
      wr(4'hf, 8'h02);
      rchk(4'hf, 8'h00);
      chk("pin a", 8'h00, {7'h00, a_oe});
      wait_oe(1'b1);
      rchk(4'hf, 8'h02);
      wr(4'he, 8'h02);
      rchk(4'h0, 8'h00);
      chk("pin a", 8'h01, {7'h00, a_oe});
      $display("test alarm done");
   endtask
   task automatic t_wave;
      wave_chk(8'h00, 1'b1);
      wave_chk(8'h08, 1'b1);
      wave_chk(8'h10, 1'b1);
      wave_chk(8'h18, 1'b1);
      wave_chk(8'h80, 1'b0);
      $display("test wave done");
   endtask
   task automatic test_done;
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_carry;
      t_alarm;
      t_wave;
      test_done;
   end
   // the whole sequence needs well under a millisecond
   initial begin
      #2000000;
      fails++;
      test_done;
   end
endmodule // testbench
`default_nettype wire
